// File: sim/gdc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module gdc_dev_model (
    input wire logic sys_clk,
    input wire logic supply_ok,
    input wire logic pwm_o,
    input wire logic pwm_oe,
    input wire logic off_n_o,
    input wire logic node_high,
    input wire logic over_temp,
    output logic temp_ready,
    output logic temp_fault,
    output logic hi_gate,
    output logic lo_gate
);
    logic flt_q;
    logic [5:0] deg_q;
    wire logic tri_lvl = !pwm_oe;
    wire logic drive = supply_ok && !flt_q;
    assign hi_gate = drive && !tri_lvl && pwm_o;
    assign lo_gate = drive && !tri_lvl && !pwm_o && off_n_o;
    assign temp_ready = supply_ok && !flt_q;
    assign temp_fault = flt_q;
    always_ff @(posedge sys_clk) begin
        deg_q <= (supply_ok && over_temp) ? deg_q + 6'h01 : 6'h00;
        if (!supply_ok) flt_q <= 1'b0;
        else if ((lo_gate && node_high) ||
            deg_q >= 6'(gdc_pkg::OVER_TEMP_DEGLITCH_NS / gdc_pkg::CLK_PERIOD_NS)) flt_q <= 1'b1;
    end
endmodule // gdc_dev_model
`default_nettype wire

// File: sim/test_gdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_gdc_host;
    import gdc_pkg::*;
    logic sys_clk = 0, rst_n = 0, run_en = 0, cmd_ls_en = 0, temp_hot = 0;
    logic supply_ok = 0, node_high = 0, over_temp = 0;
    gdc_level_t cmd_level = LVL_TRI;
    logic temp_ready, temp_fault, pwm_o, pwm_oe, off_n_o, running, fault_seen, throttle, hi_gate, lo_gate;
    int err_total = 0, n_compared = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    gdc_host i_gdc_host (.sys_clk, .rst_n, .run_en, .cmd_level, .cmd_ls_en, .temp_ready, .temp_fault,
        .temp_hot, .pwm_o, .pwm_oe, .off_n_o, .running, .fault_seen, .throttle);
    gdc_dev_model i_gdc_dev_model (.sys_clk, .supply_ok, .pwm_o, .pwm_oe, .off_n_o, .node_high,
        .over_temp, .temp_ready, .temp_fault, .hi_gate, .lo_gate);
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_start();
        run_en = 1;
        step(3);
        chk({running, pwm_oe}, 2'h0);
        supply_ok = 1;
        step(2);
        chk({hi_gate, lo_gate}, 2'h0);
        $display("test start done");
    endtask
    task automatic t_drive();
        cmd_level = LVL_HIGH;
        cmd_ls_en = 1;
        step(3);
        chk({pwm_oe, pwm_o}, 2'h3);
        chk({hi_gate, lo_gate}, 2'h2);
        cmd_level = LVL_LOW;
        step(2);
        chk({hi_gate, lo_gate}, 2'h1);
        cmd_ls_en = 0;
        step(2);
        chk({off_n_o, lo_gate}, 2'h0);
        cmd_level = LVL_TRI;
        temp_hot = 1;
        step(2);
        chk({pwm_oe, hi_gate}, 2'h0);
        chk({throttle, running}, 2'h3);
        run_en = 0;
        step(2);
        chk({running, throttle}, 2'h1);
        run_en = 1;
        $display("test drive done");
    endtask
    task automatic t_fault();
        cmd_level = LVL_LOW;
        cmd_ls_en = 1;
        step(2);
        node_high = 1;
        step(3);
        chk({fault_seen, running}, 2'h2);
        chk({pwm_oe, off_n_o}, 2'h0);
        node_high = 0;
        step(3);
        chk({temp_fault, lo_gate}, 2'h2);
        $display("test short done");
    endtask
    task automatic t_otemp();
        rst_n = 0;
        supply_ok = 0;
        step(2);
        chk({temp_fault, fault_seen}, 2'h0);
        rst_n = 1;
        supply_ok = 1;
        cmd_level = LVL_HIGH;
        over_temp = 1;
        step(30);
        chk({temp_fault, hi_gate}, 2'h1);
        step(1);
        chk({temp_fault, hi_gate}, 2'h2);
        step(2);
        chk({temp_fault, fault_seen}, 2'h3);
        chk({hi_gate, lo_gate}, 2'h0);
        $display("test overtemp done");
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 500) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        step(12);
        rst_n = 1;
        t_start();
        t_drive();
        t_fault();
        t_otemp();
        final_report();
    end
endmodule // test_gdc_host
`default_nettype wire

// File: verilog/gdc_host.sv
// Notes on behaviour
// - Host holds each PWM level minimum time while running; stop or fault tri-states at once
// - Host waits for temperature report first
// - Host shuts stage down on fault
// - Host throttles load on high temperature
`timescale 1ns/1ps
`default_nettype none
module gdc_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run_en,
    input wire gdc_pkg::gdc_level_t cmd_level,
    input wire logic cmd_ls_en,
    input wire logic temp_ready,
    input wire logic temp_fault,
    input wire logic temp_hot,
    output logic pwm_o,
    output logic pwm_oe,
    output logic off_n_o,
    output logic running,
    output logic fault_seen,
    output logic throttle
);
    import gdc_pkg::*;

    gdc_state_t state_q, state_d;
    gdc_level_t lvl_q, lvl_d;
    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] need;
    logic pwm_q, pwm_oe_q, off_n_q, fault_q, throttle_q, running_q;

    // Fault wins over everything; start only once temperature is reported
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT: begin
                if (temp_fault) begin
                    state_d = ST_SHUT;
                end else if (temp_ready && run_en) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (temp_fault) begin
                    state_d = ST_SHUT;
                end else if (!run_en) begin
                    state_d = ST_WAIT;
                end
            end
            ST_SHUT: state_d = ST_SHUT;
        endcase
    end

    // Tri-state must outlast the device hold-off to take effect
    always_comb begin
        need = (lvl_q == LVL_TRI) ? HOLDOFF_CYC : MIN_PULSE_CYC;
    end

    always_comb begin
        lvl_d = lvl_q;
        if (state_d != ST_RUN) begin
            lvl_d = LVL_TRI;
        end else if (cmd_level != lvl_q && hold_q >= need) begin
            lvl_d = cmd_level;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lvl_q <= LVL_TRI;
            hold_q <= HOLD_RESET;
        end else begin
            lvl_q <= lvl_d;
            if (lvl_d != lvl_q) begin
                hold_q <= HOLD_W'(1);
            end else if (hold_q != {HOLD_W{1'b1}}) begin
                hold_q <= hold_q + HOLD_W'(1);
            end
        end
    end

    // Pin drive; releasing PWM lets the device float it to tri-state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
            pwm_oe_q <= 1'b0;
            off_n_q <= 1'b0;
        end else begin
            pwm_q <= (lvl_d == LVL_HIGH);
            pwm_oe_q <= (lvl_d != LVL_TRI);
            off_n_q <= (state_d == ST_RUN) && cmd_ls_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
            throttle_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            fault_q <= (state_d == ST_SHUT);
            running_q <= (state_d == ST_RUN);
            throttle_q <= temp_hot;
        end
    end

    assign pwm_o = pwm_q;
    assign pwm_oe = pwm_oe_q;
    assign off_n_o = off_n_q;
    assign running = running_q;
    assign fault_seen = fault_q;
    assign throttle = throttle_q;

    property p_fault_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        temp_fault |=> (!pwm_oe_q && !off_n_q && fault_q);
    endproperty
    a_fault_stop: assert property (p_fault_stop) else $error("drive not released after fault");

    property p_shut_latched;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == ST_SHUT) |=> (state_q == ST_SHUT) && !pwm_oe_q && fault_q;
    endproperty
    a_shut_latched: assert property (p_shut_latched) else $error("shutdown left without reset");

    property p_wait_ready;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(running_q) |-> $past(temp_ready) && $past(run_en) && !$past(temp_fault);
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("PWM driven before temperature report");

    property p_min_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == ST_RUN && $past(state_q) == ST_RUN && lvl_q != $past(lvl_q)) |->
            $past(hold_q) >= $past(need);
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("PWM level held too briefly");

    property p_throttle;
        @(posedge sys_clk) disable iff (!rst_n)
        temp_hot ##1 temp_hot |=> throttle_q && $past(throttle_q);
    endproperty
    a_throttle: assert property (p_throttle) else $error("throttle not following temperature");

    property p_idle_released;
        @(posedge sys_clk) disable iff (!rst_n)
        !running_q |-> !pwm_oe_q && !off_n_q;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("pins driven while not running");

    property p_released_low;
        @(posedge sys_clk) disable iff (!rst_n)
        !pwm_oe_q |-> !pwm_q;
    endproperty
    a_released_low: assert property (p_released_low) else $error("PWM value high while released");

    property p_ls_only_run;
        @(posedge sys_clk) disable iff (!rst_n)
        off_n_q |-> running_q && !fault_q;
    endproperty
    a_ls_only_run: assert property (p_ls_only_run) else $error("low side enabled outside run");

    property p_fault_no_run;
        @(posedge sys_clk) disable iff (!rst_n)
        fault_q |-> !running_q && !pwm_oe_q;
    endproperty
    a_fault_no_run: assert property (p_fault_no_run) else $error("running after fault");

    property p_stop_request;
        @(posedge sys_clk) disable iff (!rst_n)
        running_q && !run_en |=> !running_q && !pwm_oe_q;
    endproperty
    a_stop_request: assert property (p_stop_request) else $error("drive kept after run request dropped");

    property p_throttle_low;
        @(posedge sys_clk) disable iff (!rst_n)
        !temp_hot |=> !throttle_q;
    endproperty
    a_throttle_low: assert property (p_throttle_low) else $error("throttle kept while cool");

    property p_pwm_needs_run;
        @(posedge sys_clk) disable iff (!rst_n)
        pwm_q |-> pwm_oe_q && running_q;
    endproperty
    a_pwm_needs_run: assert property (p_pwm_needs_run) else $error("PWM high outside run");

    property p_fault_kept;
        @(posedge sys_clk) disable iff (!rst_n)
        fault_q |=> fault_q;
    endproperty
    a_fault_kept: assert property (p_fault_kept) else $error("fault indication dropped");

    property p_tri_first;
        @(posedge sys_clk) disable iff (!rst_n)
        (running_q && $past(running_q) && $rose(pwm_oe_q)) |-> $past(hold_q) >= HOLDOFF_CYC;
    endproperty
    a_tri_first: assert property (p_tri_first) else $error("tri-state left before hold-off");

    property p_ls_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        (running_q && !$past(cmd_ls_en)) |-> !off_n_q;
    endproperty
    a_ls_follow: assert property (p_ls_follow) else $error("low side enabled against request");
endmodule // gdc_host
`default_nettype wire

// File: verilog/gdc_pkg.sv
`default_nettype none
package gdc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_PULSE_NS = 30;
    localparam int HOLDOFF_LOW_NS = 41;
    localparam int HOLDOFF_HIGH_NS = 45;
    localparam int OVER_TEMP_DEGLITCH_NS = 3000;
    localparam int HOLD_W = 4;
    localparam logic [HOLD_W-1:0] MIN_PULSE_CYC =
        HOLD_W'((MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [HOLD_W-1:0] HOLDOFF_CYC =
        HOLD_W'((HOLDOFF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [HOLD_W-1:0] HOLD_RESET = 4'h0;

    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_HIGH,
        LVL_TRI
    } gdc_level_t;

    typedef enum logic [1:0] {
        ST_WAIT,
        ST_RUN,
        ST_SHUT
    } gdc_state_t;
endpackage
`default_nettype wire
